//--- hw/scm_defines.svh
/*
 * Register map, field positions, reset values and oscillator counts
 * for the system clock and mode controller.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// Register byte addresses
`define SCM_ADDR_MODE   8'h00
`define SCM_ADDR_CTRL   8'h04
`define SCM_ADDR_STAT   8'h08
`define SCM_ADDR_W      8

// Mode register fields
`define SCM_CKS_HI      7
`define SCM_CKS_LO      5
`define SCM_FAST_BIT    4
`define SCM_LRDY_BIT    3
`define SCM_HRDY_BIT    2
`define SCM_IDLE_BIT    1
`define SCM_HL_BIT      0
`define SCM_MODE_RST    8'h03

// Control register fields
`define SCM_KEEP_BIT    0
`define SCM_LVD_BIT     1
`define SCM_WDT_BIT     2
`define SCM_CTRL_RST    3'h0

// Divider codes
`define SCM_CKS_FIRST_H 3'h2
`define SCM_CKS_TOP     4'h8

// Ready delays in oscillator cycles
`define SCM_LXT_CYCLES  10'h080
`define SCM_INTERNAL_LOW_RC_CYCLES 10'h002
`define SCM_HXT_CYCLES  10'h200
`define SCM_INTERNAL_HIGH_RC_CYCLES 10'h010

`endif

//--- hw/scm_pkg.sv
/*
 * Types shared by the clock and mode controller files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scm_pkg;

	// Operating modes
	typedef enum logic [2:0] {
		SCM_NORMAL,
		SCM_SLOW,
		SCM_IDLE_OFF,
		SCM_IDLE_ON,
		SCM_DEEP_SLEEP,
		SCM_WDT_SLEEP
	} scm_mode_e;

endpackage

//--- hw/scm_tick_div.sv
/*
 * Divides a tick stream by a power of two from 1 to 64.
 * Assumes the input tick is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/100ps
`include "scm_defines.svh"

module scm_tick_div #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Source and ratio
	input  wire logic             tick_in,
	input  wire logic [2:0]       shift,
	// Divided tick
	output logic                  tick_out
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] mask;

	// Mask of low bits that must all be set for a pulse
	assign mask = WIDTH'((1 << shift) - 1);

	// Free counter of source ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count <= '0;
		else if (tick_in)
			count <= count + WIDTH'(1);
	end

	// One pulse every 2^shift source ticks, or every 2^WIDTH when shift exceeds WIDTH
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_out <= 1'b0;
		else
			tick_out <= tick_in && ((count & mask) == mask);
	end

endmodule

//--- hw/scm_osc_ready.sv
/*
 * Oscillator ready flag: low while held, high after a count of
 * oscillator ticks once released.
 * Assumes ticks are one-cycle pulses from a running oscillator.
 */
`timescale 1ns/100ps
`include "scm_defines.svh"

module scm_osc_ready #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             hold,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] limit,
	// Flag
	output logic                  ready
);

	logic [WIDTH-1:0] count;

	// Count ticks until the limit, restart on hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			ready <= 1'b0;
		end else if (hold) begin
			count <= '0;
			ready <= 1'b0;
		end else if (tick && !ready) begin
			count <= count + WIDTH'(1);
			ready <= (count + WIDTH'(1)) >= limit;
		end
	end

endmodule

//--- hw/scm_clock_mode.sv
/*
 * System clock selection and operating mode control, with an APB
 * register file. Oscillators appear as one-cycle tick inputs and the
 * clocks it hands out are tick enables.
 * Assumes oscillator ticks and CPU strobes synchronous to pclk.
 */
// What this block does
// (RL1) System clock from high or substitute clock
// (RL2) High clock: crystal or RC by option
// (RL3) Substitute clock: crystal or RC by option
// (RL4) Divided high clock spans /2 to /64
// (RL5) Substitute and time base from low oscillator
// (RL6) Substitute clock bridges wake-up when enabled; not with the RC high clock
// (RL7) Substitute system clock stops high oscillator
// (RL8) Normal mode: high clock divided 1..64
// (RL9) Slow mode: low clock, high off
// (RL10) Deep sleep stops CPU, substitute, watchdog
// (RL11) Low voltage detect on blocks deep sleep
// (RL12) Watchdog sleep keeps substitute clock running
// (RL13) Idle-off stops CPU and high oscillator
// (RL14) Idle-on keeps system oscillator for peripherals
// (RL15) Watchdog picks sleep kind; time base gating
// (RL16) Divider codes map substitute, /64../2
// (RL17) Low ready after 128 or 2 ticks
`timescale 1ns/100ps
`include "scm_defines.svh"

module scm_clock_mode (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Configuration options, 1 selects the RC oscillator
	input  wire logic        high_src_rc,
	input  wire logic        low_src_rc,
	// Oscillator ticks
	input  wire logic        high_osc_tick,
	input  wire logic        low_osc_tick,
	// CPU events
	input  wire logic        halt_req,
	input  wire logic        wake_req,
	// Clock enables and status
	output logic             system_clock,
	output logic             substitute_clock,
	output logic             time_base_clock,
	output logic             high_speed_clock,
	output logic             high_osc_enable,
	output logic             low_osc_enable,
	output logic             cpu_run,
	output logic             watchdog_run,
	output logic [2:0]       mode
);

	logic [2:0]          clock_divider_select;
	logic                fast_wake_enable;
	logic                idle_select;
	logic                high_low_clock_select;
	logic                idle_keep_clock;
	logic                low_voltage_detect_enable;
	logic                watchdog_enable;
	logic                low_osc_ready_flag;
	logic                high_osc_ready_flag;
	logic                temp_sub;
	logic                high_div_tick;
	logic                sel_sub;
	logic [2:0]          div_shift;
	logic [7:0]          mode_reg_view;
	logic                wr_en;
	logic                addr_ok;
	localparam logic [7:0] mode_reset_value = `SCM_MODE_RST;
	scm_pkg::scm_mode_e  state;
	scm_pkg::scm_mode_e  next_state;
	scm_pkg::scm_mode_e  run_mode;

	////////////////////////////////////////////////////////////////////
	// Clock source decode

	// Codes 000 and 001 both mean the substitute clock
	assign sel_sub = !high_low_clock_select &&
		(clock_divider_select < `SCM_CKS_FIRST_H); // RL16 RL1
	// 010 gives /64, halving up to 111 for /2; select high gives /1
	assign div_shift = high_low_clock_select ? 3'h0 :
		3'(`SCM_CKS_TOP - {1'b0, clock_divider_select}); // RL16 RL4 RL8
	assign run_mode = sel_sub ? scm_pkg::SCM_SLOW : scm_pkg::SCM_NORMAL;

	// High clock source is whichever oscillator the option chose
	scm_tick_div #(
		.WIDTH(6)
	) u_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick_in  (high_osc_tick && high_osc_enable), // RL2
		.shift    (div_shift),
		.tick_out (high_div_tick)
	);

	////////////////////////////////////////////////////////////////////
	// Operating mode machine

	// Halt picks the CPU-off mode; wake returns to the running mode
	always_comb begin
		next_state = state;
		case (state)
			scm_pkg::SCM_NORMAL, scm_pkg::SCM_SLOW: begin
				if (halt_req) begin
					if (idle_select)
						next_state = idle_keep_clock ? scm_pkg::SCM_IDLE_ON // RL14
							: scm_pkg::SCM_IDLE_OFF; // RL13
					else if (watchdog_enable)
						next_state = scm_pkg::SCM_WDT_SLEEP; // RL12 RL15
					else if (!low_voltage_detect_enable) // RL11
						next_state = scm_pkg::SCM_DEEP_SLEEP; // RL10 RL15
					// Low voltage detect on: halt is refused
				end else begin
					next_state = run_mode;
				end
			end
			scm_pkg::SCM_IDLE_OFF, scm_pkg::SCM_IDLE_ON,
			scm_pkg::SCM_DEEP_SLEEP, scm_pkg::SCM_WDT_SLEEP: begin
				if (wake_req)
					next_state = run_mode;
			end
			default: next_state = run_mode;
		endcase
	end

	// Mode state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= scm_pkg::SCM_NORMAL;
		else
			state <= next_state;
	end

	// Fast wake: run from the substitute clock until the crystal is up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			temp_sub <= 1'b0;
		else if (cpu_run && high_osc_ready_flag)
			temp_sub <= 1'b0;
		else if (wake_req && !cpu_run && fast_wake_enable && !high_src_rc && !sel_sub)
			temp_sub <= 1'b1; // RL6
	end

	////////////////////////////////////////////////////////////////////
	// Oscillator gating and ready flags

	// High oscillator runs only where the system clock needs it
	assign high_osc_enable = !sel_sub &&
		(state == scm_pkg::SCM_NORMAL || state == scm_pkg::SCM_IDLE_ON); // RL7 RL9 RL13
	// Low oscillator stops only in deep sleep
	assign low_osc_enable = state != scm_pkg::SCM_DEEP_SLEEP; // RL10 RL12

	// Low oscillator ready: cleared in deep sleep, counts after wake
	scm_osc_ready #(
		.WIDTH(10)
	) u_low_rdy (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (!low_osc_enable),
		.tick    (low_osc_tick),
		.limit   (low_src_rc ? `SCM_INTERNAL_LOW_RC_CYCLES : `SCM_LXT_CYCLES), // RL17
		.ready   (low_osc_ready_flag)
	);

	// High oscillator ready, same scheme
	scm_osc_ready #(
		.WIDTH(10)
	) u_high_rdy (
		.pclk    (pclk),
		.presetn (presetn),
		.hold    (!high_osc_enable),
		.tick    (high_osc_tick),
		.limit   (high_src_rc ? `SCM_INTERNAL_HIGH_RC_CYCLES : `SCM_HXT_CYCLES),
		.ready   (high_osc_ready_flag)
	);

	////////////////////////////////////////////////////////////////////
	// Clock enables out

	// Registered so the enables are glitch free for their consumers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock     <= 1'b0;
			substitute_clock <= 1'b0;
			time_base_clock  <= 1'b0;
			high_speed_clock <= 1'b0;
		end else begin
			case (state)
				scm_pkg::SCM_NORMAL:
					system_clock <= temp_sub ? low_osc_tick : high_div_tick; // RL6 RL8
				scm_pkg::SCM_SLOW:
					system_clock <= low_osc_tick; // RL9
				scm_pkg::SCM_IDLE_ON:
					system_clock <= sel_sub ? low_osc_tick : high_div_tick; // RL14
				default:
					system_clock <= 1'b0; // RL10 RL13
			endcase
			substitute_clock <= low_osc_enable && low_osc_tick; // RL3 RL5
			time_base_clock  <= low_osc_tick && state != scm_pkg::SCM_DEEP_SLEEP &&
				state != scm_pkg::SCM_WDT_SLEEP; // RL5 RL15
			// No undivided high clock for peripherals while it is stopped
			high_speed_clock <= high_osc_enable && high_osc_tick; // RL7
		end
	end

	assign cpu_run      = state == scm_pkg::SCM_NORMAL || state == scm_pkg::SCM_SLOW;
	assign watchdog_run = watchdog_enable && state != scm_pkg::SCM_DEEP_SLEEP; // RL10
	assign mode         = state;

	////////////////////////////////////////////////////////////////////
	// APB registers

	assign addr_ok = paddr == `SCM_ADDR_MODE || paddr == `SCM_ADDR_CTRL ||
		paddr == `SCM_ADDR_STAT;
	assign wr_en   = psel && penable && pwrite && addr_ok;
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !addr_ok;

	// Mode register view, ready flags are read only
	assign mode_reg_view = {clock_divider_select, fast_wake_enable, low_osc_ready_flag,
		high_osc_ready_flag, idle_select, high_low_clock_select};

	// Mode register fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{clock_divider_select, fast_wake_enable} <= mode_reset_value[`SCM_CKS_HI:`SCM_FAST_BIT];
			idle_select           <= mode_reset_value[`SCM_IDLE_BIT];
			high_low_clock_select <= mode_reset_value[`SCM_HL_BIT];
		end else if (wr_en && paddr == `SCM_ADDR_MODE) begin
			clock_divider_select  <= pwdata[`SCM_CKS_HI:`SCM_CKS_LO];
			fast_wake_enable      <= pwdata[`SCM_FAST_BIT];
			idle_select           <= pwdata[`SCM_IDLE_BIT];
			high_low_clock_select <= pwdata[`SCM_HL_BIT];
		end
	end

	// Control register fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{watchdog_enable, low_voltage_detect_enable, idle_keep_clock} <= `SCM_CTRL_RST;
		end else if (wr_en && paddr == `SCM_ADDR_CTRL) begin
			idle_keep_clock           <= pwdata[`SCM_KEEP_BIT];
			low_voltage_detect_enable <= pwdata[`SCM_LVD_BIT]; // RL11
			watchdog_enable           <= pwdata[`SCM_WDT_BIT];
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable) begin
			case (paddr)
				`SCM_ADDR_MODE: prdata <= {24'h00_0000, mode_reg_view};
				`SCM_ADDR_CTRL: prdata <= {29'h0, watchdog_enable,
					low_voltage_detect_enable, idle_keep_clock};
				`SCM_ADDR_STAT: prdata <= {27'h0, temp_sub, cpu_run, mode};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	// Refused halt leaves the CPU running
	property p_lvd_blocks;
		@(posedge pclk) disable iff (!presetn)
		cpu_run && halt_req && !idle_select && !watchdog_enable && low_voltage_detect_enable
			|=> cpu_run;
	endproperty
	a_lvd_blocks: assert property (p_lvd_blocks) else $error("halt entered sleep with lvd on"); // RL11

	property p_deep;
		@(posedge pclk) disable iff (!presetn)
		cpu_run && halt_req && !idle_select && !watchdog_enable && !low_voltage_detect_enable
			|=> state == scm_pkg::SCM_DEEP_SLEEP ##1 !substitute_clock && !watchdog_run;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep not entered or clock left on"); // RL10

	property p_wdt_sleep;
		@(posedge pclk) disable iff (!presetn)
		cpu_run && halt_req && !idle_select && watchdog_enable
			|=> state == scm_pkg::SCM_WDT_SLEEP && low_osc_enable;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog sleep wrong"); // RL12

	property p_idle_off;
		@(posedge pclk) disable iff (!presetn)
		cpu_run && halt_req && idle_select && !idle_keep_clock
			|=> !cpu_run && !high_osc_enable ##1 !system_clock;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("idle-off left a clock on"); // RL13

	property p_idle_on;
		@(posedge pclk) disable iff (!presetn)
		cpu_run && halt_req && idle_select && idle_keep_clock && !sel_sub
			|=> state == scm_pkg::SCM_IDLE_ON && high_osc_enable;
	endproperty
	a_idle_on: assert property (p_idle_on) else $error("idle-on stopped oscillator"); // RL14

	property p_slow_high_off;
		@(posedge pclk) disable iff (!presetn)
		state == scm_pkg::SCM_SLOW |-> !high_osc_enable ##1 !high_speed_clock;
	endproperty
	a_slow_high_off: assert property (p_slow_high_off) else $error("high clock on in slow"); // RL7

	property p_tbc_sleep;
		@(posedge pclk) disable iff (!presetn)
		(state == scm_pkg::SCM_WDT_SLEEP)[*2] |-> !time_base_clock;
	endproperty
	a_tbc_sleep: assert property (p_tbc_sleep) else $error("time base ran in sleep"); // RL15

	property p_code_sub;
		@(posedge pclk) disable iff (!presetn)
		!high_low_clock_select && clock_divider_select == 3'h1 && !halt_req && cpu_run
			|=> state == scm_pkg::SCM_SLOW;
	endproperty
	a_code_sub: assert property (p_code_sub) else $error("code 001 not substitute"); // RL16

	property p_lrdy_cleared;
		@(posedge pclk) disable iff (!presetn)
		state == scm_pkg::SCM_DEEP_SLEEP |=> !low_osc_ready_flag;
	endproperty
	a_lrdy_cleared: assert property (p_lrdy_cleared) else $error("low ready high in deep sleep"); // RL17

endmodule

//--- verification/scm_clock_mode_bench.sv
/*
 * Self-checking bench for scm_clock_mode: divider codes, halt/wake modes, ready flags, APB map.
 * Assumes the design files under hw/ and oscillator ticks modelled here as pclk-synchronous pulses.
 */
`timescale 1ns/100ps
`include "scm_defines.svh"

module scm_clock_mode_bench;

	////////////////////////////////////////////////////////////////////////////
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, high_src_rc = 0, low_src_rc = 0;
	logic        high_osc_tick = 0, low_osc_tick = 0, halt_req = 0, wake_req = 0;
	logic        system_clock, substitute_clock, time_base_clock, high_speed_clock;
	logic        high_osc_enable, low_osc_enable, cpu_run, watchdog_run;
	logic [2:0]  mode;
	int          fails = 0, checks_done = 0, cycles = 0;
	int          n_sys, n_sub, n_tbc, n_hsc, ex, st;

	scm_clock_mode uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.high_src_rc(high_src_rc), .low_src_rc(low_src_rc), .high_osc_tick(high_osc_tick),
		.low_osc_tick(low_osc_tick), .halt_req(halt_req), .wake_req(wake_req), .system_clock(system_clock),
		.substitute_clock(substitute_clock), .time_base_clock(time_base_clock),
		.high_speed_clock(high_speed_clock), .high_osc_enable(high_osc_enable),
		.low_osc_enable(low_osc_enable), .cpu_run(cpu_run), .watchdog_run(watchdog_run), .mode(mode));

	////////////////////////////////////////////////////////////////////////////
	// Clock, oscillators that tick only while enabled, pulse counters, hang limit
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		high_osc_tick <= high_osc_enable === 1'b1;
		low_osc_tick  <= low_osc_enable === 1'b1 && cycles % 4 == 0;
		n_sys += system_clock;
		n_sub += substitute_clock;
		n_tbc += time_base_clock;
		n_hsc += high_speed_clock;
		// Pulse counts are ints, so an unknown enable would otherwise count as zero
		if (presetn && $isunknown({system_clock, substitute_clock, time_base_clock, high_speed_clock, mode})) begin
			fails++;
			$display("wrong value at %0t: unknown clock enable or mode", $time);
		end
		if (cycles == 60000) begin
			fails++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One APB transfer, released only after pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d | ($urandom & 32'hFFFF_FF00);
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Pulse counts: divider phase may shift one pulse either way
	task automatic chk_rate(input int got, input int exp, input string what);
		checks_done++;
		if (got > exp + 1 || got < exp - 1) begin
			fails++;
			$display("wrong value at %0t: %s count %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic window(input int n);
		n_sys = 0;
		n_sub = 0;
		n_tbc = 0;
		n_hsc = 0;
		repeat (n) @(posedge pclk);
	endtask

	task automatic pulse(input logic h);
		@(posedge pclk);
		if (h) halt_req <= 1;
		else wake_req <= 1;
		@(posedge pclk);
		halt_req <= 0;
		wake_req <= 0;
		repeat (3) @(posedge pclk);
	endtask

	// Mode expected after a halt; 0 means the halt is refused
	function automatic int exp_mode(input int i);
		if (i[0]) return i[1] ? 3 : 2;
		if (i[3]) return 5;
		return i[2] ? 0 : 4;
	endfunction

	// System clock pulses per 256 cycles for a divider code with high ticks every cycle
	function automatic int exp_sys(input int code);
		return code < 2 ? 64 : 256 >> (8 - code);
	endfunction

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(13));
		repeat (16) @(posedge pclk);
		presetn <= 1;
		repeat (700) @(posedge pclk);
		// Reset values and the unmapped hole
		apb(0, `SCM_ADDR_MODE, 0);
		chk(rd, 32'h0F, "mode reg reset");
		apb(0, `SCM_ADDR_CTRL, 0);
		chk(rd, 32'h0, "ctrl reg reset");
		apb(0, `SCM_ADDR_STAT, 0);
		chk(rd, 32'h08, "status reset");
		apb(1, 8'h0C, 32'hFF);
		chk({31'h0, err}, 32'h1, "unmapped write error");
		apb(0, 8'h0C, 0);
		chk({rd[30:0], err}, 32'h1, "unmapped read");
		$display("test reset done");

		// Every divider code, then high/low select set for the undivided clock
		for (int c = 0; c < 9; c++) begin
			apb(1, `SCM_ADDR_MODE, c < 8 ? c << 5 : 32'h01);
			repeat (700) @(posedge pclk);
			window(256);
			chk_rate(n_sys, c < 8 ? exp_sys(c) : 256, "system clock rate");
			chk({29'h0, mode}, c < 2 ? 1 : 0, "mode after select");
			chk({31'h0, high_osc_enable}, c > 1, "high osc enable");
			chk_rate(n_hsc, c < 2 ? 0 : 256, "high clock pulses");
			chk_rate(n_sub, 64, "substitute pulses");
		end
		$display("test divider done");

		// All halt conditions in turn from a random start, each followed by a wake
		st = $urandom % 16;
		for (int k = 0; k < 16; k++) begin
			int i;
			i = (st + k) % 16;
			ex = exp_mode(i);
			apb(1, `SCM_ADDR_MODE, i[0] ? 32'h03 : 32'h01);
			apb(1, `SCM_ADDR_CTRL, (i >> 1) & 7);
			pulse(1);
			chk({29'h0, mode}, ex, "mode after halt");
			chk({31'h0, cpu_run}, ex == 0, "cpu run");
			chk({31'h0, watchdog_run}, i[3] && ex != 4, "watchdog run");
			chk({31'h0, high_osc_enable}, ex == 0 || ex == 3, "high osc in halt");
			chk({31'h0, low_osc_enable}, ex != 4, "low osc in halt");
			window(64);
			chk_rate(n_sub, ex == 4 ? 0 : 16, "substitute in halt");
			chk_rate(n_tbc, ex > 3 ? 0 : 16, "time base in halt");
			chk_rate(n_sys, ex == 0 || ex == 3 ? 64 : 0, "system clock in halt");
			if (ex == 4) begin
				apb(0, `SCM_ADDR_MODE, 0);
				chk({31'h0, rd[3]}, 0, "low ready in deep sleep");
			end
			pulse(0);
			if (ex == 4) begin
				repeat (380) @(posedge pclk);
				apb(0, `SCM_ADDR_MODE, 0);
				chk({31'h0, rd[3]}, 0, "low ready early");
				repeat (200) @(posedge pclk);
				apb(0, `SCM_ADDR_MODE, 0);
				chk({31'h0, rd[3]}, 1, "low ready late");
			end
			repeat (600) @(posedge pclk);
			chk({29'h0, mode}, 0, "mode after wake");
		end
		$display("test halt done");

		// Fast wake from deep sleep: substitute ticks until the crystal is ready
		apb(1, `SCM_ADDR_CTRL, 0);
		apb(1, `SCM_ADDR_MODE, 32'h11);
		pulse(1);
		pulse(0);
		window(64);
		chk_rate(n_sys, 16, "fast wake system clock");
		apb(0, `SCM_ADDR_STAT, 0);
		chk(rd, 32'h18, "fast wake active");
		repeat (600) @(posedge pclk);
		apb(0, `SCM_ADDR_STAT, 0);
		chk(rd, 32'h08, "fast wake over");
		window(256);
		chk_rate(n_sys, 256, "high clock after fast wake");
		$display("test fast wake done");

		// RC options: short ready delay, no fast wake with the RC high clock
		high_src_rc <= 1;
		low_src_rc <= 1;
		apb(1, `SCM_ADDR_CTRL, 0);
		apb(1, `SCM_ADDR_MODE, 32'h11);
		pulse(1);
		pulse(0);
		repeat (20) @(posedge pclk);
		apb(0, `SCM_ADDR_MODE, 0);
		chk({30'h0, rd[3:2]}, 3, "rc ready flags");
		apb(0, `SCM_ADDR_STAT, 0);
		chk(rd, 32'h08, "rc blocks fast wake");
		window(256);
		chk_rate(n_sys, 256, "rc system clock");
		$display("test rc options done");
		print_verdict();
	end

endmodule
